// ### core/ufu_pkg.sv
package ufu_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;  // core clock rate
  localparam int unsigned BAUD_BPS    = 31_250;      // serial bit rate
  localparam int unsigned OVERSAMPLE  = 16;          // ticks per bit
  // cycles per oversample tick, exactly 80 at this clock
  localparam int unsigned TICK_CYCLES = CLK_HZ / (BAUD_BPS * OVERSAMPLE);
  localparam logic [3:0]  MID_TICK    = 4'h7;        // sample point in a bit
  localparam logic [3:0]  LAST_TICK   = 4'hf;        // end of a bit
  localparam logic [3:0]  STOP_BIT    = 4'h9;        // index of stop bit
  localparam logic [7:0]  CMD_BEGIN   = 8'h10;       // begin_update_cmd
  localparam logic [7:0]  CMD_ERASE   = 8'h11;       // erase command
  localparam logic [7:0]  CMD_WRITE   = 8'h12;       // write command
  localparam logic [7:0]  RSP_READY   = 8'h55;       // ready answer
  localparam logic [7:0]  LOWEST_ALLOWED_BLOCK  = 8'h02;
  localparam logic [7:0]  HIGHEST_ALLOWED_BLOCK = 8'h15;
  localparam int unsigned UNIT_BYTES  = 256;         // data unit length
  localparam logic [1:0]  SIZE_LAST   = 2'h3;        // fourth size byte
  localparam int unsigned LED_W       = 4;           // indicator count
  localparam logic [3:0]  LEDS_OFF_N  = 4'hf;        // all dark
  localparam logic [3:0]  CHASE_INIT  = 4'h1;        // first lit in chase
  localparam logic [3:0]  ERR_RX      = 4'h1;        // overrun or framing
  localparam logic [3:0]  ERR_BEGIN   = 4'h2;        // not a begin command
  localparam logic [3:0]  ERR_ERASE   = 4'h3;        // not an erase command
  localparam logic [3:0]  ERR_BLOCK   = 4'h4;        // block out of range
  localparam logic [3:0]  ERR_EFAIL   = 4'h5;        // erase failed
  localparam logic [3:0]  ERR_WRITE   = 4'h6;        // not a write command
  localparam logic [3:0]  ERR_SIZE    = 4'h7;        // bad write size
  localparam logic [3:0]  ERR_PFAIL   = 4'h8;        // program failed
  localparam logic [3:0]  ERR_NONE    = 4'h0;

  typedef enum logic [3:0] {
    S_WAIT_BEGIN, S_WAIT_ERASE, S_WAIT_BLOCK, S_ERASING, S_WAIT_WRITE,
    S_WAIT_SIZE, S_CHECK_SIZE, S_WAIT_DATA, S_PROGRAM, S_SEND_READY,
    S_DONE, S_ERROR
  } ufu_state_t;
endpackage

// ### core/ufu_ser_if.sv
`timescale 1ns/1ps
// byte level link between the sequencer and the serial engine
interface ufu_ser_if;
  logic [7:0] rx_byte;      // received byte, held while rx_valid
  logic       rx_valid;     // byte waiting to be taken
  logic       rx_ack;       // sequencer takes the byte
  logic       frame_err;    // one-cycle pulse, stop bit was low
  logic       overrun_err;  // one-cycle pulse, byte lost
  logic       tx_start;     // one-cycle request to send tx_data
  logic [7:0] tx_data;      // byte to send
  logic       tx_busy;      // frame on the line

  modport uart (output rx_byte, rx_valid, frame_err, overrun_err, tx_busy,
                input rx_ack, tx_start, tx_data);
  modport core (input rx_byte, rx_valid, frame_err, overrun_err, tx_busy,
                output rx_ack, tx_start, tx_data);
endinterface

// ### core/ufu_uart.sv
`timescale 1ns/1ps
module ufu_uart (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic rxd,
  output logic      txd,
  ufu_ser_if.uart   ser
);
  import ufu_pkg::*;
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);

  logic [TICK_W-1:0] tick_cnt_reg;   // oversample divider
  logic              tick;           // one-cycle enable, 16 per bit
  logic              rxd_meta_reg;   // first sync stage, read by second only
  logic              rxd_sync_reg;   // line level safe to use
  logic              rx_busy_reg;    // inside a frame
  logic [3:0]        rx_os_reg;      // tick within the bit
  logic [3:0]        rx_bit_reg;     // 0 start, 1..8 data, 9 stop
  logic [7:0]        rx_shift_reg;   // data assembled lsb first
  logic [7:0]        rx_byte_reg;    // byte handed over
  logic              rx_pend_reg;    // handed byte not yet taken
  logic              ferr_reg;       // framing pulse
  logic              oerr_reg;       // overrun pulse
  logic              tx_busy_reg;    // sending
  logic [3:0]        tx_os_reg;      // tick within the bit
  logic [3:0]        tx_bit_reg;     // bits already sent
  logic [9:0]        tx_shift_reg;   // stop, data, start
  logic              txd_reg;        // line driver
  logic              rx_mid;         // sampling instant
  logic              rx_stop;        // stop bit sampled
  logic              rx_good;        // frame complete, stop high
  logic              rx_lost;        // new byte while old still pending

  assign tick    = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
  assign rx_mid  = tick && rx_busy_reg && (rx_os_reg == MID_TICK);
  assign rx_stop = rx_mid && (rx_bit_reg == STOP_BIT);
  assign rx_good = rx_stop && rxd_sync_reg;
  assign rx_lost = rx_good && rx_pend_reg && !ser.rx_ack;
  assign ser.rx_byte     = rx_byte_reg;
  assign ser.rx_valid    = rx_pend_reg;
  assign ser.frame_err   = ferr_reg;
  assign ser.overrun_err = oerr_reg;
  assign ser.tx_busy     = tx_busy_reg;
  assign txd             = txd_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_reg <= '0;
    else        tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
  end

  // pin comes from the far device, two stages before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // receive 8 data bits, no parity, one stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_reg  <= 1'b0;
      rx_os_reg    <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
    end else if (tick && !rx_busy_reg) begin
      rx_busy_reg <= !rxd_sync_reg;  // low line at a tick opens a frame
      rx_os_reg   <= '0;
      rx_bit_reg  <= '0;
    end else if (tick) begin
      rx_os_reg <= rx_os_reg + 1'b1;
      if (rx_os_reg == MID_TICK) begin
        rx_bit_reg <= rx_bit_reg + 1'b1;
        // a start bit gone high by mid bit was a glitch
        if ((rx_bit_reg == '0 && rxd_sync_reg) || rx_bit_reg == STOP_BIT)
          rx_busy_reg <= 1'b0;
        else if (rx_bit_reg != '0)
          rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
      end
    end
  end

  // hand-over holding stage; a new byte wins over a take
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_reg <= '0;
      rx_pend_reg <= 1'b0;
      ferr_reg    <= 1'b0;
      oerr_reg    <= 1'b0;
    end else begin
      if (rx_good && !rx_lost) begin
        rx_byte_reg <= rx_shift_reg;
        rx_pend_reg <= 1'b1;
      end else if (ser.rx_ack) begin
        rx_pend_reg <= 1'b0;
      end
      // low stop bit flags a framing fault
      ferr_reg <= rx_stop && !rxd_sync_reg;
      oerr_reg <= rx_lost;  // the older byte is kept, the new one dropped
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_reg  <= 1'b0;
      tx_os_reg    <= '0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= '1;
      txd_reg      <= 1'b1;
    end else begin
      txd_reg <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
      if (ser.tx_start && !tx_busy_reg) begin
        tx_busy_reg  <= 1'b1;
        tx_shift_reg <= {1'b1, ser.tx_data, 1'b0};
        tx_os_reg    <= '0;
        tx_bit_reg   <= '0;
      end else if (tick && tx_busy_reg) begin
        tx_os_reg <= tx_os_reg + 1'b1;
        if (tx_os_reg == LAST_TICK) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
          tx_bit_reg   <= tx_bit_reg + 1'b1;
          if (tx_bit_reg == STOP_BIT) tx_busy_reg <= 1'b0;
        end
      end
    end
  end
endmodule

// ### core/ufu_update_slave.sv
`timescale 1ns/1ps
module ufu_update_slave #(
  parameter int unsigned ADDR_W       = 24,         // flash address width
  parameter int unsigned BLOCK_SHIFT  = 14,         // log2 of block bytes
  parameter int unsigned CHASE_CYCLES = 4_000_000   // completion chase step
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       rxd,
  output logic                            txd,
  output logic [ufu_pkg::LED_W-1:0]       led_n,
  output logic                            flash_erase_req,
  output logic [7:0]                      flash_erase_block,
  input  wire logic                       flash_erase_done,
  input  wire logic                       flash_erase_fail,
  output logic                            flash_prog_req,
  output logic [ADDR_W-1:0]               flash_prog_addr,
  output logic [7:0]                      flash_prog_data,
  input  wire logic                       flash_prog_done,
  input  wire logic                       flash_prog_fail
);
  import ufu_pkg::*;
  localparam logic [31:0] BLOCK_BYTES = 32'h1 << BLOCK_SHIFT;
  localparam int unsigned CHASE_W     = $clog2(CHASE_CYCLES);

  ufu_state_t        state_reg;          // sequence position
  ufu_state_t        ret_reg;            // where to go after the ready byte
  logic [3:0]        err_code_reg;       // latched error number
  logic [31:0]       size_reg;           // write size, first byte is msb
  logic [1:0]        size_cnt_reg;       // size bytes seen
  logic [23:0]       units_left_reg;     // data units still to come
  logic [7:0]        wr_idx_reg;         // fill position in unit buffer
  logic [7:0]        prog_idx_reg;       // drain position in unit buffer
  logic              prog_wait_reg;      // program request outstanding
  logic              erase_req_reg;
  logic [7:0]        erase_block_reg;
  logic              prog_req_reg;
  logic [ADDR_W-1:0] prog_addr_reg;
  logic [7:0]        prog_data_reg;
  logic              tx_start_reg;       // ready byte request
  logic [3:0]        led_n_reg;
  logic [3:0]        chase_reg;          // one-hot lit indicator
  logic [CHASE_W-1:0] chase_cnt_reg;
  logic [7:0]        buf_mem [UNIT_BYTES]; // one data unit

  logic rx_fault;   // receiver reported a lost or broken byte
  logic waiting;    // sequencer expects a byte now
  logic halted;     // done or error, bytes are dropped
  logic rx_new;     // byte to act on this cycle
  logic size_bad;   // write size out of range
  logic unit_last;  // final unit being programmed
  logic unit_end;   // last byte of a unit programmed
  logic chase_step; // slow enable for the chase

  ufu_ser_if ser ();

  ufu_uart u_uart (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rxd      (rxd),
    .txd      (txd),
    .ser      (ser)
  );

  // range test, shared by the sequence and its checks
  function automatic logic block_ok(input logic [7:0] blk);
    return (blk >= LOWEST_ALLOWED_BLOCK) && (blk <= HIGHEST_ALLOWED_BLOCK);
  endfunction

  assign rx_fault  = ser.frame_err || ser.overrun_err;
  assign halted    = (state_reg == S_DONE) || (state_reg == S_ERROR);
  assign waiting   = state_reg inside {S_WAIT_BEGIN, S_WAIT_ERASE, S_WAIT_BLOCK,
                                       S_WAIT_WRITE, S_WAIT_SIZE, S_WAIT_DATA};
  assign rx_new    = ser.rx_valid && waiting;
  // bytes arriving while busy stay pending; a second one then overruns
  assign ser.rx_ack  = ser.rx_valid && (waiting || halted);
  assign ser.tx_start = tx_start_reg;
  // the only byte ever sent back
  assign ser.tx_data  = RSP_READY;
  // zero or larger than the block
  assign size_bad  = (size_reg == '0) || (size_reg > BLOCK_BYTES);
  assign unit_last = (units_left_reg == 24'h1);
  assign unit_end  = prog_wait_reg && flash_prog_done && !flash_prog_fail
                     && (prog_idx_reg == 8'hff);
  assign chase_step = (chase_cnt_reg == CHASE_W'(CHASE_CYCLES - 1));
  assign flash_erase_req   = erase_req_reg;
  assign flash_erase_block = erase_block_reg;
  assign flash_prog_req    = prog_req_reg;
  assign flash_prog_addr   = prog_addr_reg;
  assign flash_prog_data   = prog_data_reg;
  assign led_n             = led_n_reg;

  // main sequence; request strobes default low each cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_WAIT_BEGIN;
      ret_reg <= S_WAIT_BEGIN;
      err_code_reg <= ERR_NONE;
      size_reg <= '0;
      size_cnt_reg <= '0;
      units_left_reg <= '0;
      wr_idx_reg <= '0;
      prog_idx_reg <= '0;
      prog_wait_reg <= 1'b0;
      erase_req_reg <= 1'b0;
      erase_block_reg <= '0;
      prog_req_reg <= 1'b0;
      prog_addr_reg <= '0;
      prog_data_reg <= '0;
      tx_start_reg <= 1'b0;
    end else begin
      erase_req_reg <= 1'b0;
      prog_req_reg  <= 1'b0;
      tx_start_reg  <= 1'b0;
      // receive faults beat any other step
      if (rx_fault && !halted) begin
        err_code_reg <= ERR_RX;
        state_reg    <= S_ERROR;
      end else begin
        unique case (state_reg)
          // each command wait accepts one command only
          S_WAIT_BEGIN: if (rx_new) begin
            if (ser.rx_byte == CMD_BEGIN) begin
              ret_reg <= S_WAIT_ERASE;
              state_reg <= S_SEND_READY;
            end else begin
              err_code_reg <= ERR_BEGIN;
              state_reg <= S_ERROR;
            end
          end
          S_WAIT_ERASE: if (rx_new) begin
            if (ser.rx_byte == CMD_ERASE) begin
              ret_reg <= S_WAIT_BLOCK;
              state_reg <= S_SEND_READY;
            end else begin
              err_code_reg <= ERR_ERASE;
              state_reg <= S_ERROR;
            end
          end
          S_WAIT_BLOCK: if (rx_new) begin
            if (block_ok(ser.rx_byte)) begin
              erase_block_reg <= ser.rx_byte;
              erase_req_reg <= 1'b1;
              state_reg <= S_ERASING;
            end else begin
              err_code_reg <= ERR_BLOCK;
              state_reg <= S_ERROR;
            end
          end
          // erase first, programming starts at block base
          S_ERASING: if (flash_erase_done) begin
            if (flash_erase_fail) begin
              err_code_reg <= ERR_EFAIL;
              state_reg <= S_ERROR;
            end else begin
              prog_addr_reg <= ADDR_W'(erase_block_reg) << BLOCK_SHIFT;
              ret_reg <= S_WAIT_WRITE;
              state_reg <= S_SEND_READY;
            end
          end
          S_WAIT_WRITE: if (rx_new) begin
            if (ser.rx_byte == CMD_WRITE) begin
              size_cnt_reg <= '0;
              ret_reg <= S_WAIT_SIZE;
              state_reg <= S_SEND_READY;
            end else begin
              err_code_reg <= ERR_WRITE;
              state_reg <= S_ERROR;
            end
          end
          // four size bytes, no answer between them
          S_WAIT_SIZE: if (rx_new) begin
            size_reg <= {size_reg[23:0], ser.rx_byte};
            size_cnt_reg <= size_cnt_reg + 1'b1;
            if (size_cnt_reg == SIZE_LAST) state_reg <= S_CHECK_SIZE;
          end
          S_CHECK_SIZE: if (size_bad) begin
            err_code_reg <= ERR_SIZE;
            state_reg <= S_ERROR;
          end else begin
            units_left_reg <= 24'(size_reg[31:8] + 24'(|size_reg[7:0]));
            wr_idx_reg <= '0;
            ret_reg <= S_WAIT_DATA;
            state_reg <= S_SEND_READY;
          end
          S_WAIT_DATA: if (rx_new) begin
            wr_idx_reg <= wr_idx_reg + 1'b1;
            if (wr_idx_reg == 8'hff) begin
              prog_idx_reg <= '0;
              prog_wait_reg <= 1'b0;
              state_reg <= S_PROGRAM;
            end
          end
          // sequential programming, one byte per request
          S_PROGRAM: if (!prog_wait_reg) begin
            prog_req_reg <= 1'b1;
            prog_data_reg <= buf_mem[prog_idx_reg];
            prog_wait_reg <= 1'b1;
          end else if (flash_prog_done) begin
            if (flash_prog_fail) begin
              err_code_reg <= ERR_PFAIL;
              state_reg <= S_ERROR;
            end else begin
              prog_wait_reg <= 1'b0;
              prog_addr_reg <= prog_addr_reg + 1'b1;
              prog_idx_reg <= prog_idx_reg + 1'b1;
            end
            if (unit_end) begin
              units_left_reg <= units_left_reg - 1'b1;
              ret_reg <= unit_last ? S_DONE : S_WAIT_DATA;
              state_reg <= S_SEND_READY;
            end
          end
          // ready byte only after processing is over
          S_SEND_READY: if (!ser.tx_busy) begin
            tx_start_reg <= 1'b1;
            state_reg <= ret_reg;
          end
          S_DONE, S_ERROR: state_reg <= state_reg;
        endcase
      end
    end
  end

  // unit buffer, no reset needed for data storage
  always_ff @(posedge core_clk) begin
    if (rx_new && state_reg == S_WAIT_DATA) buf_mem[wr_idx_reg] <= ser.rx_byte;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_n_reg <= LEDS_OFF_N;
      chase_reg <= CHASE_INIT;
      chase_cnt_reg <= '0;
    end else begin
      chase_cnt_reg <= chase_step ? '0 : chase_cnt_reg + 1'b1;
      if (chase_step) chase_reg <= {chase_reg[2:0], chase_reg[3]};
      if (state_reg == S_ERROR)     led_n_reg <= ~err_code_reg;
      else if (state_reg == S_DONE) led_n_reg <= ~chase_reg;
      else                          led_n_reg <= LEDS_OFF_N;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // a request while a frame is out would be lost by the transmitter
  a_ready_byte_value: assert property (
    ser.tx_start |-> ser.tx_data == RSP_READY && !ser.tx_busy)
    else $error("answer byte lost or not the ready value");
  a_ready_after_work: assert property (
    tx_start_reg |-> !prog_wait_reg && $past(state_reg) == S_SEND_READY)
    else $error("ready sent while processing");
  a_block_range_ok: assert property (flash_erase_req |-> block_ok(flash_erase_block))
    else $error("erase issued for a protected block");
  a_bad_block_err: assert property (
    state_reg == S_WAIT_BLOCK && rx_new && !rx_fault && !block_ok(ser.rx_byte)
    |=> state_reg == S_ERROR && err_code_reg == ERR_BLOCK)
    else $error("bad block not trapped");
  a_rx_fault_err: assert property (
    rx_fault && !halted |=> state_reg == S_ERROR && err_code_reg == ERR_RX)
    else $error("receive fault not trapped");
  a_wrong_cmd_err: assert property (
    state_reg == S_WAIT_BEGIN && rx_new && !rx_fault && ser.rx_byte != CMD_BEGIN
    |=> err_code_reg == ERR_BEGIN)
    else $error("unexpected command accepted");
  a_size_check_err: assert property (
    state_reg == S_CHECK_SIZE && size_bad && !rx_fault |=> err_code_reg == ERR_SIZE)
    else $error("bad size accepted");
  a_error_led_hold: assert property (
    state_reg == S_ERROR |=> state_reg == S_ERROR ##1 led_n == ~err_code_reg)
    else $error("error state or code not held");
  c_erase_issued: cover property (flash_erase_req);
  c_unit_programmed: cover property (unit_end);
  c_update_done: cover property (state_reg == S_DONE);
  c_rx_fault_seen: cover property (rx_fault && !halted);
endmodule

// ### test/ufu_master_model.sv
`timescale 1ns/1ps
// master side: drives frames on rxd, decodes answers from txd
module ufu_master_model (
  input  wire logic core_clk,
  output logic      rxd,
  input  wire logic txd
);
  import ufu_pkg::*;
  localparam int BIT_CYCLES = TICK_CYCLES * OVERSAMPLE;  // cycles per bit
  int starts;  // falling edges seen on txd
  initial begin
    rxd    = 1'b1;
    starts = 0;
  end
  // count txd falling edges, so silence can be checked
  always @(negedge txd) starts++;
  // start, 8 data lsb first, stop
  task automatic send_byte(input logic [7:0] b, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = frame[i];
      // good stop cut short: the answer may start before a full stop ends
      repeat ((i == 9 && stop_ok) ? BIT_CYCLES / 4 : BIT_CYCLES) @(negedge core_clk);
    end
    rxd = 1'b1;
  endtask
  // sample each answer bit mid cell
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    b  = 8'h00;
    while (txd !== 1'b0 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT_CYCLES / 2) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(negedge core_clk);
        b[i] = txd;
      end
      repeat (BIT_CYCLES) @(negedge core_clk);
      ok = (txd === 1'b1);
    end
  endtask
endmodule

// ### test/ufu_update_slave_tb.sv
`timescale 1ns/1ps
// bench: master model on the link, flash answers after one cycle
module ufu_update_slave_tb;
  import ufu_pkg::*;
  logic       core_clk;              // 40 mhz core clock
  logic       rst_n;                 // async reset, low active
  logic       rxd;                   // master to slave
  logic       txd;                   // slave to master
  logic [3:0] led_n;                 // indicators, low lit
  logic       erase_req, erase_done; // erase handshake
  logic       prog_req, prog_done;   // program handshake
  int         fail_count, compares, cycles;

  ufu_update_slave #(.CHASE_CYCLES(16)) i_ufu_update_slave (
    .core_clk(core_clk), .rst_n(rst_n), .rxd(rxd), .txd(txd), .led_n(led_n),
    .flash_erase_req(erase_req), .flash_erase_block(), .flash_erase_done(erase_done),
    .flash_erase_fail(1'b0), .flash_prog_req(prog_req), .flash_prog_addr(),
    .flash_prog_data(), .flash_prog_done(prog_done), .flash_prog_fail(1'b0)
  );
  ufu_master_model i_ufu_master_model (.core_clk(core_clk), .rxd(rxd), .txd(txd));

  always #12.5 core_clk = ~core_clk;
  // flash never fails here; the program fail path needs the long data phase
  always @(negedge core_clk) begin
    erase_done <= erase_req;
    prog_done  <= prog_req;
  end
  // hang guard, well above the six frames the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // reset for six cycles, then idle while the synchroniser fills
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic expect_leds(input logic [3:0] exp);
    compares++;
    if (led_n !== exp) begin
      fail_count++;
      $display("MISMATCH %0t leds %h want %h", $time, led_n, exp);
    end
  endtask
  task automatic expect_silent(input int s);
    compares++;
    if (i_ufu_master_model.starts != s) begin
      fail_count++;
      $display("MISMATCH %0t unexpected answer", $time);
    end
  endtask
  // begin answered with ready, then write where erase is due
  task automatic sc_wrong_erase();
    logic [7:0] b;
    logic       ok;
    do_reset();
    expect_leds(4'hf);
    i_ufu_master_model.send_byte(CMD_BEGIN, 1'b1);
    i_ufu_master_model.get_byte(b, ok);
    compares++;
    if (ok !== 1'b1 || b !== 8'h55) begin
      fail_count++;
      $display("MISMATCH %0t ready byte %h", $time, b);
    end
    expect_leds(4'hf);
    i_ufu_master_model.send_byte(CMD_WRITE, 1'b1);
    // the cut stop returns before the slave samples its middle
    repeat (1000) @(negedge core_clk);
    expect_leds(~4'h3);
  endtask
  // error code stays and bytes get no answer
  task automatic sc_error_held();
    int s;
    s = i_ufu_master_model.starts;
    i_ufu_master_model.send_byte(CMD_ERASE, 1'b1);
    repeat (1500) @(negedge core_clk);
    expect_leds(~4'h3);
    expect_silent(s);
  endtask
  // erase before begin
  task automatic sc_wrong_begin();
    do_reset();
    expect_leds(4'hf);
    i_ufu_master_model.send_byte(CMD_ERASE, 1'b1);
    // stop bit middle comes after the cut stop returns
    repeat (1000) @(negedge core_clk);
    expect_leds(~4'h2);
  endtask
  // low stop bit on a valid begin
  task automatic sc_frame_err();
    int s;
    do_reset();
    s = i_ufu_master_model.starts;
    i_ufu_master_model.send_byte(CMD_BEGIN, 1'b0);
    repeat (40) @(negedge core_clk);
    expect_leds(~4'h1);
    expect_silent(s);
  endtask

  initial begin
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    erase_done = 1'b0;
    prog_done  = 1'b0;
    fail_count = 0;
    compares   = 0;
    cycles     = 0;
    @(negedge core_clk);
    sc_wrong_erase();
    sc_error_held();
    sc_wrong_begin();
    sc_frame_err();
    finish_test();
  end
endmodule
